// >>> logic/pif_flags.v
// Second peripheral interrupt flag register with Avalon-MM slave and masked interrupt
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pif_map.vh"

// Three-flop input filter with change and rising-edge detection for one event source
module pif_sync #(
  parameter IDLE_LEVEL = 1'b0
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_pin,
  input wire i_arm,
  output wire o_change,
  output wire o_rise
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg level_ff;
  wire agree;

  // Only stage two reads stage one; stage three guards against a late metastable flip
  assign agree = ~(s2_ff ^ s3_ff);
  assign o_change = i_arm & agree & (level_ff ^ s3_ff);
  assign o_rise = o_change & s3_ff;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_ff <= IDLE_LEVEL;
      s2_ff <= IDLE_LEVEL;
      s3_ff <= IDLE_LEVEL;
      level_ff <= IDLE_LEVEL;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Before arming the reference tracks the pin, so start-up levels raise nothing
      if (!i_arm) begin
        level_ff <= s3_ff;
      end else if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

endmodule

// One sticky flag: an event sets it, software clears it, and a set in the same cycle wins
module pif_flag_bit #(
  parameter RESET_VALUE = 1'b0
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_set,
  input wire i_clear,
  output reg o_flag
);

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_flag <= RESET_VALUE;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule

// Contract
// - Flags set on their event regardless of enable bits or global enable.
// - Bit 7 set on oscillator failure with switch to internal oscillator; software clears.
// - Bit 6 set on comparator 2 change, bit 5 on comparator 1 change.
// - Register at index 0Dh, resets zero; bits 5,4 read-only (here a written one clears them too); 3,1 read zero.
module pif_flags (
  input wire i_clk,
  input wire i_reset,
  input wire [9:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg [1:0] o_avs_response,
  input wire i_osc_fail_switch,
  input wire i_cmp_one_out,
  input wire i_cmp_two_out,
  input wire i_lcd_event,
  input wire i_lvd_event,
  input wire i_ccp_two_event,
  output reg o_irq
);

  reg [2:0] warm_cnt_ff;
  reg [7:0] mask_ff;
  reg [1:0] ccp_mode_ff;
  reg ack_ff;
  reg [7:0] clr_vec;
  reg [31:0] rd_mux;
  reg rd_ok;
  wire arm;
  wire req;
  wire wr_lo;
  wire wr_flags;
  wire wr_mask;
  wire wr_source;
  wire ccp_pwm;
  wire [7:0] flags;
  wire osc_rise;
  wire cmp_two_change;
  wire cmp_one_change;
  wire lcd_rise;
  wire lvd_rise;
  wire ccp_rise;

  // Filters arm only once their stages hold real pin samples, so no false edge follows reset
  assign arm = (warm_cnt_ff == `PIF_WARMUP_EDGES);

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      warm_cnt_ff <= 3'h0;
    end else if (!arm) begin
      warm_cnt_ff <= warm_cnt_ff + 3'h1;
    end
  end

  // Bus decode: a request acts once, in the cycle before its answer
  assign req = (i_avs_read | i_avs_write) & ~ack_ff;
  assign wr_lo = i_avs_write & ~ack_ff & i_avs_byteenable[0];
  assign wr_flags = wr_lo & (i_avs_address == `PIF_ADDR_FLAGS);
  assign wr_mask = wr_lo & (i_avs_address == `PIF_ADDR_MASK);
  assign wr_source = wr_lo & (i_avs_address == `PIF_ADDR_SOURCE);
  assign ccp_pwm = (ccp_mode_ff == `PIF_CCP_MODE_PWM);

  // Event sources arrive from other domains and pass three flops each
  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) osc_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_osc_fail_switch),
    .i_arm(arm),
    .o_change(),
    .o_rise(osc_rise)
  );

  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) cmp_two_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_cmp_two_out),
    .i_arm(arm),
    .o_change(cmp_two_change),
    .o_rise()
  );

  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) cmp_one_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_cmp_one_out),
    .i_arm(arm),
    .o_change(cmp_one_change),
    .o_rise()
  );

  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) lcd_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_lcd_event),
    .i_arm(arm),
    .o_change(),
    .o_rise(lcd_rise)
  );

  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) lvd_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_lvd_event),
    .i_arm(arm),
    .o_change(),
    .o_rise(lvd_rise)
  );

  pif_sync #(
    .IDLE_LEVEL(1'b0)
  ) ccp_sync_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_ccp_two_event),
    .i_arm(arm),
    .o_change(),
    .o_rise(ccp_rise)
  );

  // Writing a one clears a flag; software can never set one, so no event is faked
  always @* begin
    clr_vec = 8'h00;
    if (wr_flags) begin
      clr_vec = i_avs_writedata[7:0] & `PIF_IMPL_BITS;
    end
  end

  // Enables play no part in setting; set beats a clear in the same cycle
  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) osc_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(osc_rise),
    .i_clear(clr_vec[`PIF_BIT_OSC_FAIL]),
    .o_flag(flags[`PIF_BIT_OSC_FAIL])
  );

  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) cmp_two_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(cmp_two_change),
    .i_clear(clr_vec[`PIF_BIT_CMP_TWO]),
    .o_flag(flags[`PIF_BIT_CMP_TWO])
  );

  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) cmp_one_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(cmp_one_change),
    .i_clear(clr_vec[`PIF_BIT_CMP_ONE]),
    .o_flag(flags[`PIF_BIT_CMP_ONE])
  );

  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) lcd_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(lcd_rise),
    .i_clear(clr_vec[`PIF_BIT_LCD]),
    .o_flag(flags[`PIF_BIT_LCD])
  );

  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) lvd_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(lvd_rise),
    .i_clear(clr_vec[`PIF_BIT_LVD]),
    .o_flag(flags[`PIF_BIT_LVD])
  );

  pif_flag_bit #(
    .RESET_VALUE(`PIF_FLAG_BIT_RESET)
  ) ccp_flag_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(ccp_rise & ~ccp_pwm),
    .i_clear(clr_vec[`PIF_BIT_CCP_TWO]),
    .o_flag(flags[`PIF_BIT_CCP_TWO])
  );

  // Unimplemented bits read zero
  assign flags[3] = 1'b0;
  assign flags[1] = 1'b0;

  always @* begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      `PIF_ADDR_FLAGS: rd_mux = {24'h000000, flags};
      `PIF_ADDR_MASK: rd_mux = {24'h000000, mask_ff};
      `PIF_ADDR_SOURCE: rd_mux = {30'h00000000, ccp_mode_ff};
      default: rd_ok = 1'b0;
    endcase
  end

  // One-cycle wait state: each request is answered at the second edge
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mask_ff <= `PIF_MASK_RESET;
      ccp_mode_ff <= `PIF_CCP_MODE_RESET;
      ack_ff <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_avs_response <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      ack_ff <= req;
      o_avs_waitrequest <= ~req;
      if (req) begin
        o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
        o_avs_response <= rd_ok ? 2'h0 : 2'h3;
      end
      if (wr_mask) begin
        mask_ff <= i_avs_writedata[7:0] & `PIF_IMPL_BITS;
      end
      if (wr_source) begin
        ccp_mode_ff <= i_avs_writedata[1:0];
      end
      o_irq <= |(flags & mask_ff);
    end
  end

endmodule
`default_nettype wire

// >>> logic/pif_map.vh
// Register map, field positions and reset values of the second peripheral flag register
`ifndef PIF_MAP_VH
`define PIF_MAP_VH
// Printed offset 0Dh is not a multiple of four: it is an index, byte address is index * 4
`define PIF_IDX_FLAGS 8'h0D
`define PIF_IDX_MASK 8'h0E
`define PIF_IDX_SOURCE 8'h0F
`define PIF_ADDR_FLAGS 10'h034
`define PIF_ADDR_MASK 10'h038
`define PIF_ADDR_SOURCE 10'h03C
`define PIF_BIT_OSC_FAIL 7
`define PIF_BIT_CMP_TWO 6
`define PIF_BIT_CMP_ONE 5
`define PIF_BIT_LCD 4
`define PIF_BIT_LVD 2
`define PIF_BIT_CCP_TWO 0
`define PIF_FLAGS_RESET 8'h00
`define PIF_MASK_RESET 8'h00
`define PIF_FLAG_BIT_RESET 1'b0
`define PIF_WARMUP_EDGES 3'h4
`define PIF_IMPL_BITS 8'hF5
`define PIF_SW_WRITE_BITS 8'hC5
`define PIF_CCP_MODE_PWM 2'h2
`define PIF_CCP_MODE_RESET 2'h0
`endif

// >>> testbench/pif_flags_asserts.sv
// Bus timing, read layout and interrupt release checks
`timescale 1ns/1ns
`default_nettype none
module pif_flags_asserts (
  input wire i_clk,
  input wire i_reset,
  input wire [9:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire [1:0] o_avs_response,
  input wire o_irq
);
  wire req = i_avs_read || i_avs_write;
  wire ans = req && !o_avs_waitrequest;
  wire mapped = i_avs_address inside {10'h034, 10'h038, 10'h03C};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wait_one_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("answer not one cycle after request");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  read_zero_bits_a: assert property (ans && i_avs_read && i_avs_address != 10'h03C
    |-> (o_avs_readdata & 32'hFFFFFF0A) == 32'h0)
    else $error("unimplemented bits read nonzero");
  decode_err_a: assert property (ans |-> (o_avs_response == 2'h3) == !mapped)
    else $error("response code wrong for address");
  irq_release_a: assert property ($fell(o_irq) |-> $past(i_avs_write && !o_avs_waitrequest))
    else $error("interrupt dropped without a write");
  cover property (ans && i_avs_read);
  cover property (ans && i_avs_write);
  cover property ($rose(o_irq));
endmodule
bind pif_flags pif_flags_asserts pif_flags_asserts_inst (.i_clk(i_clk), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_response(o_avs_response), .o_irq(o_irq));
`default_nettype wire

// >>> testbench/test_peripheral_irq_flags_two.sv
// Register bench for the second peripheral flag register
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_irq_flags_two;
  logic clk = 0, rst = 1, rd = 0, wr = 0, wq, irq;
  logic [9:0] addr = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0] resp, rsp;
  logic [7:0] rv;
  logic [5:0] ev = 0;
  int miscompares = 0, tests_run = 0;
  always #20 clk = ~clk;
  pif_flags pif_flags_inst (.i_clk(clk), .i_reset(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_avs_response(resp),
    .i_osc_fail_switch(ev[5]), .i_cmp_two_out(ev[4]), .i_cmp_one_out(ev[3]),
    .i_lcd_event(ev[2]), .i_lvd_event(ev[1]), .i_ccp_two_event(ev[0]), .o_irq(irq));
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask
  // Request held until waitrequest is seen low; the bound cuts a hang short
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a; wd <= {24'h0, d}; wr <= w; rd <= !w;
    do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 50);
    if (n >= 50) begin miscompares++; final_report; end
    rv = rdat[7:0];
    rsp = resp;
    rd <= 0; wr <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    bus(0, 10'h034, 0); chk("flags reset", rv, 8'h00);
    bus(0, 10'h3F0, 0); chk("decode error", {6'h0, rsp}, 8'h03);
    bus(1, 10'h034, 8'hFF); bus(0, 10'h034, 0); chk("no sw set", rv, 8'h00);
    ev <= 6'h3F; repeat (8) @(posedge clk);
    bus(0, 10'h034, 0); chk("all events", rv, 8'hF5);
    chk("irq masked", {7'h0, irq}, 8'h00);
    bus(1, 10'h038, 8'h80); repeat (2) @(posedge clk); chk("irq on", {7'h0, irq}, 8'h01);
    bus(1, 10'h034, 8'h80); bus(0, 10'h034, 0); chk("osc cleared", rv, 8'h75);
    repeat (2) @(posedge clk); chk("irq off", {7'h0, irq}, 8'h00);
    bus(1, 10'h034, 8'hFF); bus(0, 10'h034, 0); chk("all cleared", rv, 8'h00);
    bus(1, 10'h038, 8'h61); repeat (2) @(posedge clk);
    chk("no stale irq", {7'h0, irq}, 8'h00);
    // PWM mode must hide a fresh capture edge
    bus(1, 10'h03C, 8'h02); ev <= 6'h3E; repeat (8) @(posedge clk); ev <= 6'h3F;
    repeat (8) @(posedge clk); bus(0, 10'h034, 0); chk("pwm hides", rv, 8'h00);
    bus(1, 10'h03C, 8'h00); ev <= 6'h27; repeat (8) @(posedge clk);
    bus(0, 10'h034, 0); chk("cmp fall", rv, 8'h60);
    chk("irq cmp", {7'h0, irq}, 8'h01);
    $display("register sequence done");
    final_report;
  end
endmodule
`default_nettype wire
